//--- core/tmwb_pkg.sv
package tmwb_pkg;

	// Bus shape.
	localparam int unsigned TMWB_AW = 8;
	localparam int unsigned TMWB_DW = 32;

	// Register byte addresses.
	localparam logic [7:0] TMWB_ADDR_CTRL_A = 8'h00;
	localparam logic [7:0] TMWB_ADDR_CTRL_B = 8'h04;
	localparam logic [7:0] TMWB_ADDR_COUNT = 8'h08;
	localparam logic [7:0] TMWB_ADDR_CMP_A = 8'h0C;
	localparam logic [7:0] TMWB_ADDR_CMP_B = 8'h10;
	localparam logic [7:0] TMWB_ADDR_IRQ_STAT = 8'h14;
	localparam logic [7:0] TMWB_ADDR_IRQ_MASK = 8'h18;
	localparam logic [7:0] TMWB_ADDR_STATE = 8'h1C;

	// Field positions.
	localparam int unsigned TMWB_OUTB_LSB = 4;
	localparam int unsigned TMWB_OUTB_MSB = 5;
	localparam int unsigned TMWB_WM_LOW_LSB = 0;
	localparam int unsigned TMWB_WM_LOW_MSB = 1;
	localparam int unsigned TMWB_WM_HIGH_BIT = 3;
	localparam int unsigned TMWB_RUN_BIT = 0;
	localparam int unsigned TMWB_ST_PIN_BIT = 0;
	localparam int unsigned TMWB_ST_UP_BIT = 1;
	localparam int unsigned TMWB_ST_OVR_BIT = 2;

	// Interrupt bits.
	localparam int unsigned TMWB_IRQ_OVF = 0;
	localparam int unsigned TMWB_IRQ_CMPA = 1;
	localparam int unsigned TMWB_IRQ_CMPB = 2;
	localparam int unsigned TMWB_IRQ_W = 3;

	// Waveform modes.
	localparam logic [2:0] TMWB_WM_NORMAL = 3'h0;
	localparam logic [2:0] TMWB_WM_PC_FF = 3'h1;
	localparam logic [2:0] TMWB_WM_CLR_MATCH = 3'h2;
	localparam logic [2:0] TMWB_WM_FAST_FF = 3'h3;
	localparam logic [2:0] TMWB_WM_RSV4 = 3'h4;
	localparam logic [2:0] TMWB_WM_PC_A = 3'h5;
	localparam logic [2:0] TMWB_WM_RSV6 = 3'h6;
	localparam logic [2:0] TMWB_WM_FAST_A = 3'h7;

	// Output mode values.
	localparam logic [1:0] TMWB_OM_OFF = 2'h0;
	localparam logic [1:0] TMWB_OM_TOGGLE = 2'h1;
	localparam logic [1:0] TMWB_OM_CLEAR = 2'h2;
	localparam logic [1:0] TMWB_OM_SET = 2'h3;

	// Counter limits and reset values.
	localparam logic [7:0] TMWB_COUNT_MAX = 8'hFF;
	localparam logic [7:0] TMWB_COUNT_BOTTOM = 8'h00;
	localparam logic [7:0] TMWB_RST_BYTE = 8'h00;
	localparam logic [31:0] TMWB_RST_WORD = 32'h0000_0000;

endpackage

//--- core/tmwb_flag.sv
`timescale 1ns/1ps

module tmwb_flag #(
	parameter logic RESET_VAL = 1'b0
) (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Set and clear.
	input wire logic set_i,
	input wire logic clr_i,
	// Flag.
	output logic flag_o
);

	logic flag_d;

	// A set in the cycle of a clear wins.
	always_comb
	begin
		flag_d = set_i | (flag_o & ~clr_i);
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			flag_o <= RESET_VAL;
		else
			flag_o <= flag_d;
	end

endmodule

//--- core/tmwb_outb.sv
`timescale 1ns/1ps

module tmwb_outb
	import tmwb_pkg::*;
(
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Mode.
	input wire logic fast_i,
	input wire logic pc_i,
	input wire logic [1:0] out_b_mode_i,
	// Counter events.
	input wire logic match_i,
	input wire logic at_top_i,
	input wire logic up_i,
	input wire logic eq_top_i,
	// Pin.
	output logic level_o,
	output logic override_o
);

	logic level_d;
	logic override_d;
	logic pwm;
	logic rsv;
	logic hi;
	logic match_ok;

	always_comb
	begin
		pwm = fast_i | pc_i;
		hi = out_b_mode_i[1];
		rsv = pwm && (out_b_mode_i == TMWB_OM_TOGGLE);
		// In PWM a match at TOP is ignored when the upper bit is set.
		match_ok = match_i && !(pwm && eq_top_i && hi);
		override_d = (out_b_mode_i != TMWB_OM_OFF) && !rsv;
		level_d = level_o;
		if (!pwm)
		begin
			if (match_ok)
			begin
				case (out_b_mode_i)
					TMWB_OM_TOGGLE: level_d = ~level_o;
					TMWB_OM_CLEAR: level_d = 1'b0;
					TMWB_OM_SET: level_d = 1'b1;
					default: level_d = level_o;
				endcase
			end
		end
		else if (hi && fast_i)
		begin
			if (at_top_i)
				level_d = (out_b_mode_i == TMWB_OM_CLEAR);
			else if (match_ok)
				level_d = (out_b_mode_i == TMWB_OM_SET);
		end
		else if (hi)
		begin
			if (at_top_i && eq_top_i)
				level_d = (out_b_mode_i == TMWB_OM_CLEAR);
			else if (match_ok)
				level_d = up_i ^ (out_b_mode_i == TMWB_OM_CLEAR);
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			level_o <= 1'b0;
			override_o <= 1'b0;
		end
		else
		begin
			level_o <= level_d;
			override_o <= override_d;
		end
	end

endmodule

//--- core/tmwb_top.sv
`timescale 1ns/1ps

module tmwb_top
	import tmwb_pkg::*;
(
	// Clock and reset.
	input wire logic SYS_CLK_I,
	input wire logic SYS_RST_I,
	// Avalon-MM slave.
	input wire logic [TMWB_AW-1:0] AVS_ADDRESS_I,
	input wire logic AVS_READ_I,
	input wire logic AVS_WRITE_I,
	input wire logic [TMWB_DW-1:0] AVS_WRITEDATA_I,
	input wire logic [3:0] AVS_BYTEENABLE_I,
	output logic [TMWB_DW-1:0] AVS_READDATA_O,
	output logic AVS_WAITREQUEST_O,
	// Compare output B pin.
	output logic OUT_B_PIN_O,
	output logic OUT_B_OVERRIDE_O,
	// Interrupt.
	output logic IRQ_O
);

	// Bus state.
	logic wait_d;
	logic [TMWB_DW-1:0] rdata_d;
	logic wr;
	logic [7:0] wbyte;

	// Configuration state.
	logic [1:0] out_b_mode_q;
	logic [1:0] out_b_mode_d;
	logic [1:0] wave_mode_low_q;
	logic [1:0] wave_mode_low_d;
	logic wave_mode_high_q;
	logic wave_mode_high_d;
	logic run_q;
	logic run_d;
	logic [TMWB_IRQ_W-1:0] mask_q;
	logic [TMWB_IRQ_W-1:0] mask_d;
	logic [7:0] cmp_a_buf_q;
	logic [7:0] cmp_a_buf_d;
	logic [7:0] cmp_b_buf_q;
	logic [7:0] cmp_b_buf_d;

	// Counter state.
	logic [7:0] count_q;
	logic [7:0] count_d;
	logic up_q;
	logic up_d;
	logic block_q;
	logic block_d;
	logic [7:0] cmp_a_q;
	logic [7:0] cmp_a_d;
	logic [7:0] cmp_b_q;
	logic [7:0] cmp_b_d;
	logic irq_d;

	// Decoded mode and events.
	logic [2:0] wave_mode_sel;
	logic is_fast;
	logic is_pc;
	logic immediate;
	logic running;
	logic [7:0] top;
	logic at_top;
	logic ovf;
	logic match_a;
	logic match_b;
	logic [TMWB_IRQ_W-1:0] irq_set;
	logic [TMWB_IRQ_W-1:0] irq_clr;
	logic [TMWB_IRQ_W-1:0] status;

	// Bus slave: one wait cycle, then the access completes.
	always_comb
	begin
		wr = AVS_WRITE_I && !AVS_WAITREQUEST_O && AVS_BYTEENABLE_I[0];
		wbyte = AVS_WRITEDATA_I[7:0];
		wait_d = !((AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O);
		rdata_d = AVS_READDATA_O;
		if (AVS_READ_I && AVS_WAITREQUEST_O)
		begin
			case (AVS_ADDRESS_I)
				TMWB_ADDR_CTRL_A: rdata_d = {26'h000_0000, out_b_mode_q, 2'h0, wave_mode_low_q};
				TMWB_ADDR_CTRL_B: rdata_d = {28'h000_0000, wave_mode_high_q, 2'h0, run_q};
				TMWB_ADDR_COUNT: rdata_d = {24'h00_0000, count_q};
				TMWB_ADDR_CMP_A: rdata_d = {24'h00_0000, cmp_a_buf_q};
				TMWB_ADDR_CMP_B: rdata_d = {24'h00_0000, cmp_b_buf_q};
				TMWB_ADDR_IRQ_STAT: rdata_d = {29'h0000_0000, status};
				TMWB_ADDR_IRQ_MASK: rdata_d = {29'h0000_0000, mask_q};
				TMWB_ADDR_STATE: rdata_d = {29'h0000_0000, OUT_B_OVERRIDE_O, up_q, OUT_B_PIN_O};
				default: rdata_d = TMWB_RST_WORD;
			endcase
		end
	end

	always_ff @(posedge SYS_CLK_I)
	begin
		if (SYS_RST_I)
		begin
			AVS_WAITREQUEST_O <= 1'b1;
			AVS_READDATA_O <= TMWB_RST_WORD;
		end
		else
		begin
			AVS_WAITREQUEST_O <= wait_d;
			AVS_READDATA_O <= rdata_d;
		end
	end

	// Configuration registers.
	always_comb
	begin
		out_b_mode_d = out_b_mode_q;
		wave_mode_low_d = wave_mode_low_q;
		wave_mode_high_d = wave_mode_high_q;
		run_d = run_q;
		mask_d = mask_q;
		cmp_a_buf_d = cmp_a_buf_q;
		cmp_b_buf_d = cmp_b_buf_q;
		if (wr)
		begin
			case (AVS_ADDRESS_I)
				TMWB_ADDR_CTRL_A:
				begin
					out_b_mode_d = wbyte[TMWB_OUTB_MSB:TMWB_OUTB_LSB];
					wave_mode_low_d = wbyte[TMWB_WM_LOW_MSB:TMWB_WM_LOW_LSB];
				end
				TMWB_ADDR_CTRL_B:
				begin
					wave_mode_high_d = wbyte[TMWB_WM_HIGH_BIT];
					run_d = wbyte[TMWB_RUN_BIT];
				end
				TMWB_ADDR_CMP_A: cmp_a_buf_d = wbyte;
				TMWB_ADDR_CMP_B: cmp_b_buf_d = wbyte;
				TMWB_ADDR_IRQ_MASK: mask_d = wbyte[TMWB_IRQ_W-1:0];
				default: mask_d = mask_q;
			endcase
		end
	end

	always_ff @(posedge SYS_CLK_I)
	begin
		if (SYS_RST_I)
		begin
			out_b_mode_q <= TMWB_OM_OFF;
			wave_mode_low_q <= 2'h0;
			wave_mode_high_q <= 1'b0;
			run_q <= 1'b0;
			mask_q <= 3'h0;
			cmp_a_buf_q <= TMWB_RST_BYTE;
			cmp_b_buf_q <= TMWB_RST_BYTE;
		end
		else
		begin
			out_b_mode_q <= out_b_mode_d;
			wave_mode_low_q <= wave_mode_low_d;
			wave_mode_high_q <= wave_mode_high_d;
			run_q <= run_d;
			mask_q <= mask_d;
			cmp_a_buf_q <= cmp_a_buf_d;
			cmp_b_buf_q <= cmp_b_buf_d;
		end
	end

	// Mode decode.
	always_comb
	begin
		wave_mode_sel = {wave_mode_high_q, wave_mode_low_q};
		is_fast = (wave_mode_sel == TMWB_WM_FAST_FF) || (wave_mode_sel == TMWB_WM_FAST_A);
		is_pc = (wave_mode_sel == TMWB_WM_PC_FF) || (wave_mode_sel == TMWB_WM_PC_A);
		immediate = (wave_mode_sel == TMWB_WM_NORMAL) || (wave_mode_sel == TMWB_WM_CLR_MATCH);
		running = run_q && (wave_mode_sel != TMWB_WM_RSV4) && (wave_mode_sel != TMWB_WM_RSV6);
		case (wave_mode_sel)
			TMWB_WM_CLR_MATCH, TMWB_WM_PC_A, TMWB_WM_FAST_A: top = cmp_a_q;
			default: top = TMWB_COUNT_MAX;
		endcase
		at_top = running && (count_q == top);
		if (is_pc)
			ovf = running && !up_q && (count_q == TMWB_COUNT_BOTTOM);
		else if (wave_mode_sel == TMWB_WM_FAST_A)
			ovf = at_top;
		else
			ovf = running && (count_q == TMWB_COUNT_MAX);
		match_a = running && !block_q && (count_q == cmp_a_q);
		match_b = running && !block_q && (count_q == cmp_b_q);
	end

	// Counter, direction and compare update.
	always_comb
	begin
		count_d = count_q;
		up_d = is_pc ? up_q : 1'b1;
		block_d = running ? 1'b0 : block_q;
		cmp_a_d = (immediate || at_top) ? cmp_a_buf_q : cmp_a_q;
		cmp_b_d = (immediate || at_top) ? cmp_b_buf_q : cmp_b_q;
		if (wr && (AVS_ADDRESS_I == TMWB_ADDR_COUNT))
		begin
			count_d = wbyte;
			block_d = 1'b1;
		end
		else if (running && is_pc)
		begin
			if (up_q && at_top)
			begin
				up_d = 1'b0;
				if (top != TMWB_COUNT_BOTTOM)
					count_d = count_q - 8'h01;
			end
			else if (up_q)
				count_d = count_q + 8'h01;
			else if (count_q == TMWB_COUNT_BOTTOM)
			begin
				up_d = 1'b1;
				count_d = count_q + 8'h01;
			end
			else
				count_d = count_q - 8'h01;
		end
		else if (running)
			count_d = at_top ? TMWB_COUNT_BOTTOM : count_q + 8'h01;
		irq_d = |(status & mask_q);
	end

	always_ff @(posedge SYS_CLK_I)
	begin
		if (SYS_RST_I)
		begin
			count_q <= TMWB_COUNT_BOTTOM;
			up_q <= 1'b1;
			block_q <= 1'b0;
			cmp_a_q <= TMWB_RST_BYTE;
			cmp_b_q <= TMWB_RST_BYTE;
			IRQ_O <= 1'b0;
		end
		else
		begin
			count_q <= count_d;
			up_q <= up_d;
			block_q <= block_d;
			cmp_a_q <= cmp_a_d;
			cmp_b_q <= cmp_b_d;
			IRQ_O <= irq_d;
		end
	end

	// Sticky event flags, cleared by writing one.
	always_comb
	begin
		irq_set = '0;
		irq_set[TMWB_IRQ_OVF] = ovf;
		irq_set[TMWB_IRQ_CMPA] = match_a;
		irq_set[TMWB_IRQ_CMPB] = match_b;
		irq_clr = (wr && (AVS_ADDRESS_I == TMWB_ADDR_IRQ_STAT)) ? wbyte[TMWB_IRQ_W-1:0] : '0;
	end

	genvar gi;
	generate
		for (gi = 0; gi < TMWB_IRQ_W; gi++)
		begin : g_flag
			tmwb_flag #(
				.RESET_VAL(1'b0)
			) u_flag (
				.clk_i(SYS_CLK_I),
				.rst_i(SYS_RST_I),
				.set_i(irq_set[gi]),
				.clr_i(irq_clr[gi]),
				.flag_o(status[gi])
			);
		end
	endgenerate

	// Channel B waveform unit.
	tmwb_outb u_outb (
		.clk_i(SYS_CLK_I),
		.rst_i(SYS_RST_I),
		.fast_i(is_fast),
		.pc_i(is_pc),
		.out_b_mode_i(out_b_mode_q),
		.match_i(match_b),
		.at_top_i(at_top),
		.up_i(up_q || (count_q == TMWB_COUNT_BOTTOM)),
		.eq_top_i(cmp_b_q == top),
		.level_o(OUT_B_PIN_O),
		.override_o(OUT_B_OVERRIDE_O)
	);

endmodule

//--- verification/tmwb_properties.sv
`timescale 1ns/1ps

module tmwb_chk
	import tmwb_pkg::*;
(
	// Clock and reset.
	input wire logic SYS_CLK_I,
	input wire logic SYS_RST_I,
	// Bus.
	input wire logic [TMWB_AW-1:0] AVS_ADDRESS_I,
	input wire logic AVS_READ_I,
	input wire logic AVS_WRITE_I,
	input wire logic [TMWB_DW-1:0] AVS_WRITEDATA_I,
	input wire logic [3:0] AVS_BYTEENABLE_I,
	input wire logic [TMWB_DW-1:0] AVS_READDATA_O,
	input wire logic AVS_WAITREQUEST_O,
	// Outputs.
	input wire logic OUT_B_OVERRIDE_O,
	input wire logic IRQ_O
);
	default clocking @(posedge SYS_CLK_I); endclocking
	default disable iff (SYS_RST_I);
	logic req, done, rdn, wr_a, wr_m;
	assign req = AVS_READ_I || AVS_WRITE_I;
	assign done = req && !AVS_WAITREQUEST_O;
	assign rdn = done && AVS_READ_I;
	assign wr_a = done && AVS_WRITE_I && AVS_BYTEENABLE_I[0]
		&& AVS_ADDRESS_I == TMWB_ADDR_CTRL_A;
	assign wr_m = done && AVS_WRITE_I && AVS_BYTEENABLE_I[0]
		&& AVS_ADDRESS_I == TMWB_ADDR_IRQ_MASK;
	sequence s_wait;
		req && AVS_WAITREQUEST_O;
	endsequence
	sequence s_done;
		done;
	endsequence
	chk_wait_once: assert property (s_wait |=> !AVS_WAITREQUEST_O)
		else $error("waitrequest late");
	chk_wait_pulse: assert property (s_done |=> AVS_WAITREQUEST_O)
		else $error("waitrequest low too long");
	chk_idle_wait: assert property (!req |=> AVS_WAITREQUEST_O)
		else $error("waitrequest low at idle");
	chk_rd_upper: assert property (rdn |-> AVS_READDATA_O[31:8] == 24'h00_0000)
		else $error("upper read bits set");
	chk_rsv_bits: assert property (rdn && AVS_ADDRESS_I == TMWB_ADDR_CTRL_A |->
		AVS_READDATA_O[7:6] == 2'h0 && AVS_READDATA_O[3:2] == 2'h0)
		else $error("reserved bits read nonzero");
	chk_ovr_on: assert property (wr_a && AVS_WRITEDATA_I[5:4] != 2'h0 &&
		!AVS_WRITEDATA_I[0] |-> ##[1:2] OUT_B_OVERRIDE_O)
		else $error("override not taken");
	chk_ovr_off: assert property (wr_a && AVS_WRITEDATA_I[5:4] == 2'h0 |->
		##[1:2] !OUT_B_OVERRIDE_O)
		else $error("override not released");
	chk_rsv_mode: assert property (wr_a && AVS_WRITEDATA_I[5:4] == 2'h1 &&
		AVS_WRITEDATA_I[0] |-> ##[1:2] !OUT_B_OVERRIDE_O)
		else $error("reserved mode drives pin");
	chk_irq_mask: assert property (wr_m && AVS_WRITEDATA_I[2:0] == 3'h0 |-> ##3 !IRQ_O)
		else $error("masked interrupt high");
endmodule

bind tmwb_top tmwb_chk u_tmwb_chk (.SYS_CLK_I, .SYS_RST_I, .AVS_ADDRESS_I, .AVS_READ_I,
	.AVS_WRITE_I, .AVS_WRITEDATA_I, .AVS_BYTEENABLE_I, .AVS_READDATA_O,
	.AVS_WAITREQUEST_O, .OUT_B_OVERRIDE_O, .IRQ_O);

//--- verification/tb_tmwb_top.sv
`timescale 1ns/1ps

module tb_tmwb_top
	import tmwb_pkg::*;
;
	logic SYS_CLK_I = 1'b0;
	logic SYS_RST_I = 1'b1;
	logic [TMWB_AW-1:0] AVS_ADDRESS_I = 8'h00;
	logic AVS_READ_I = 1'b0;
	logic AVS_WRITE_I = 1'b0;
	logic [TMWB_DW-1:0] AVS_WRITEDATA_I = 32'h0000_0000;
	logic [3:0] AVS_BYTEENABLE_I = 4'hF;
	logic [TMWB_DW-1:0] AVS_READDATA_O;
	logic AVS_WAITREQUEST_O, OUT_B_PIN_O, OUT_B_OVERRIDE_O, IRQ_O;
	logic [31:0] q;
	int err_total = 0;
	int num_checks = 0;
	int a, b, ov;
	int cs [11][4] = '{'{0, 1, 0, 5}, '{2, 1, 9, 4}, '{2, 3, 9, 4}, '{2, 2, 9, 4},
		'{3, 2, 0, 100}, '{3, 3, 0, 255}, '{7, 2, 19, 6}, '{7, 2, 19, 19},
		'{1, 2, 0, 64}, '{5, 3, 30, 10}, '{5, 2, 30, 30}};

	tmwb_top u_tmwb_top (.SYS_CLK_I, .SYS_RST_I, .AVS_ADDRESS_I, .AVS_READ_I, .AVS_WRITE_I,
		.AVS_WRITEDATA_I, .AVS_BYTEENABLE_I, .AVS_READDATA_O, .AVS_WAITREQUEST_O,
		.OUT_B_PIN_O, .OUT_B_OVERRIDE_O, .IRQ_O);

	always #2.5 SYS_CLK_I = ~SYS_CLK_I;

	task final_report;
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e)
		begin
			err_total++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask

	task acc(input logic w, input logic [7:0] ad, input logic [31:0] d);
		AVS_ADDRESS_I <= ad;
		AVS_WRITEDATA_I <= d;
		AVS_WRITE_I <= w;
		AVS_READ_I <= !w;
		@(posedge SYS_CLK_I);
		while (AVS_WAITREQUEST_O !== 1'b0)
			@(posedge SYS_CLK_I);
		q = AVS_READDATA_O;
		AVS_WRITE_I <= 1'b0;
		AVS_READ_I <= 1'b0;
		@(posedge SYS_CLK_I);
	endtask

	task rd(input string n, input logic [7:0] ad, input logic [31:0] e);
		acc(1'b0, ad, 32'h0000_0000);
		chk(n, e, q);
	endtask

	// The model counts high cycles and rising edges over two waveform periods.
	task automatic run_case(input int wm, input int om, input int ca, input int cb);
		int p, hi, top, h, r;
		logic l;
		top = (wm == 2 || wm > 4) ? ca : 255;
		if (wm == 3 || wm == 7)
		begin
			p = top + 1;
			hi = (cb >= top) ? p : cb + 1;
		end
		else if (wm % 2 == 1)
		begin
			p = 2 * top;
			hi = 2 * cb;
		end
		else
		begin
			p = 2 * top + 2;
			hi = (om == 1) ? top + 1 : (om == 3) ? p : 0;
		end
		if (wm % 2 == 1 && om == 3)
			hi = p - hi;
		acc(1'b1, TMWB_ADDR_CTRL_B, 32'h0000_0000);
		acc(1'b1, TMWB_ADDR_CMP_A, ca);
		acc(1'b1, TMWB_ADDR_CMP_B, cb);
		acc(1'b1, TMWB_ADDR_COUNT, 32'h0000_0000);
		acc(1'b1, TMWB_ADDR_CTRL_A, om * 16 + wm % 4);
		acc(1'b1, TMWB_ADDR_CTRL_B, (wm / 4) * 8 + 1);
		repeat (2 * p + 600)
			@(posedge SYS_CLK_I);
		h = 0;
		r = 0;
		l = OUT_B_PIN_O;
		repeat (2 * p)
		begin
			@(posedge SYS_CLK_I);
			h += (OUT_B_PIN_O === 1'b1);
			r += (OUT_B_PIN_O === 1'b1 && l === 1'b0);
			l = OUT_B_PIN_O;
		end
		chk("pin high", 2 * hi, h);
		chk("pin edges", (hi == 0 || hi == p) ? 0 : 2, r);
		acc(1'b1, TMWB_ADDR_IRQ_STAT, 32'h0000_0007);
		repeat (2 * p)
			@(posedge SYS_CLK_I);
		rd("flags", TMWB_ADDR_IRQ_STAT, (wm == 2 && ca < 255) ? 6 : 7);
		$display("case mode %0d out %0d done", wm, om);
	endtask

	initial
	begin
		void'($urandom(32'h8640_242d));
		repeat (2)
			@(posedge SYS_CLK_I);
		SYS_RST_I <= 1'b0;
		@(posedge SYS_CLK_I);
		chk("pins", 32'h0000_0000, {OUT_B_PIN_O, OUT_B_OVERRIDE_O, IRQ_O});
		acc(1'b1, 8'h20, 32'h0000_00FF);
		AVS_BYTEENABLE_I <= 4'h0;
		acc(1'b1, TMWB_ADDR_CTRL_A, 32'h0000_00FF);
		AVS_BYTEENABLE_I <= 4'hF;
		for (int i = 0; i < 9; i++)
			rd("reset", 8'(i * 4), (i == 7) ? 32'h0000_0002 : 32'h0000_0000);
		acc(1'b1, TMWB_ADDR_CTRL_A, 32'h0000_00FF);
		rd("ctrl a", TMWB_ADDR_CTRL_A, 32'h0000_0033);
		for (int i = 0; i < 32; i++)
		begin
			acc(1'b1, TMWB_ADDR_CTRL_B, (i / 16) * 8);
			acc(1'b1, TMWB_ADDR_CTRL_A, (i % 4) * 16 + (i / 4) % 4);
			ov = (i % 4 != 0) && !((i / 4) % 2 == 1 && i % 4 == 1);
			rd("state", TMWB_ADDR_STATE, ov * 4 + 2);
			chk("override", ov, OUT_B_OVERRIDE_O);
			rd("ctrl b", TMWB_ADDR_CTRL_B, (i / 16) * 8);
		end
		$display("register test done");
		foreach (cs[i])
			run_case(cs[i][0], cs[i][1], cs[i][2], cs[i][3]);
		repeat (3)
		begin
			a = 8 + $urandom % 33;
			b = 1 + $urandom % (a - 1);
			run_case(7, 2 + $urandom % 2, a, b);
		end
		acc(1'b1, TMWB_ADDR_IRQ_STAT, 32'h0000_0007);
		repeat (100)
			@(posedge SYS_CLK_I);
		rd("status", TMWB_ADDR_IRQ_STAT, 32'h0000_0007);
		acc(1'b1, TMWB_ADDR_IRQ_MASK, 32'h0000_0001);
		repeat (3)
			@(posedge SYS_CLK_I);
		chk("irq", 32'h0000_0001, IRQ_O);
		acc(1'b1, TMWB_ADDR_IRQ_MASK, 32'h0000_0000);
		repeat (3)
			@(posedge SYS_CLK_I);
		chk("irq", 32'h0000_0000, IRQ_O);
		acc(1'b1, TMWB_ADDR_CTRL_B, 32'h0000_0000);
		acc(1'b1, TMWB_ADDR_COUNT, 32'h0000_00C8);
		acc(1'b1, TMWB_ADDR_IRQ_MASK, 32'h0000_0007);
		acc(1'b1, TMWB_ADDR_IRQ_STAT, 32'h0000_0007);
		repeat (3)
			@(posedge SYS_CLK_I);
		chk("irq", 32'h0000_0000, IRQ_O);
		rd("status", TMWB_ADDR_IRQ_STAT, 32'h0000_0000);
		acc(1'b1, TMWB_ADDR_CTRL_A, 32'h0000_0000);
		acc(1'b1, TMWB_ADDR_CTRL_B, 32'h0000_0009);
		repeat (20)
			@(posedge SYS_CLK_I);
		rd("count", TMWB_ADDR_COUNT, 32'h0000_00C8);
		$display("interrupt test done");
		final_report;
	end

	initial
	begin
		#300us;
		err_total++;
		final_report;
	end
endmodule
